/* hdl/pc_stack_status_unit.sv */
// program counter, return stack and status flags of the core with an apb window
// Function
// RULE_01 - alu flag update beats status write
// RULE_02 - expiry and power-down bits never written
// RULE_03 - subtraction carry means not-borrow
// RULE_04 - 15-bit counter, low byte accessible
// RULE_05 - any reset clears whole counter
// RULE_06 - low byte write loads upper latch
// RULE_07 - call: operand 10:0, latch 6:3
// RULE_08 - accumulator call: low accumulator, high latch
// RULE_09 - accumulator jump: pc+1+unsigned accumulator
// RULE_10 - literal jump: pc+1+signed operand
// RULE_11 - sixteen entry 15-bit return stack
// RULE_12 - calls and irq push, returns pop
// RULE_13 - push and pop keep upper latch
// RULE_14 - fault reset off: stack wraps circularly
// RULE_15 - full and empty-pop flags always set
// RULE_16 - fault reset on: reset with flag
// RULE_17 - index and top entry pair accessible
// RULE_18 - push increments first, pop decrements after
// RULE_19 - nibble bit from low nibble carry
// RULE_20 - expiry flag set/cleared by watchdog events
// RULE_21 - power-down flag set/cleared by instructions
// RULE_22 - zero flag tracks result zero
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module pc_stack_status_unit
  import pcs_pkg::*;
#(
  parameter logic [14:0] IRQ_VECTOR = 15'h0004
)
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // flow requests from the decoder
  input wire pcs_pkg::flow_op_e I_OP,
  input wire logic [10:0] I_CALL_TARGET,
  input wire logic [8:0] I_REL_OFFSET,
  input wire logic [7:0] I_ACCUM,
  input wire logic [7:0] I_LOW_WDATA,
  // alu result for the flags
  input wire logic I_ALU_VALID,
  input wire logic I_ALU_ARITH,
  input wire logic I_ALU_SUB,
  input wire logic [7:0] I_ALU_A,
  input wire logic [7:0] I_ALU_B,
  input wire logic [7:0] I_ALU_RESULT,
  // instruction write into status
  input wire logic I_STATUS_WE,
  input wire logic [7:0] I_STATUS_WDATA,
  // watchdog and sleep events
  input wire logic I_WDT_CLEAR,
  input wire logic I_SLEEP,
  input wire logic I_WDT_TIMEOUT,
  // flow outputs
  output logic [14:0] O_PC,
  output logic [7:0] O_STATUS,
  output logic O_STACK_FAULT_RESET
);

  // ==========================================================
  // state
  logic [14:0] pc_r; // program counter
  logic [14:0] pc_nxt;
  logic [6:0] latch_r; // upper pc latch
  logic [6:0] latch_nxt;
  logic [7:0] status_r; // status register
  logic [7:0] status_nxt;
  logic [3:0] idx_r; // stack index
  logic [3:0] idx_nxt;
  logic [4:0] count_r; // live entries, 0..16
  logic [4:0] count_nxt;
  logic fault_en_r; // stack fault reset enable
  logic full_r; // stack full flag
  logic full_nxt;
  logic empty_pop_r; // stack empty pop flag
  logic empty_pop_nxt;
  logic fault_rst_r; // one-cycle fault reset pulse
  logic [14:0] stack_mem [STACK_DEPTH]; // return stack storage

  // ==========================================================
  // apb decode
  logic pready_r; // answer on second access cycle
  logic [31:0] prdata_r;
  logic pslverr_r;
  wire access = I_PSEL && I_PENABLE;
  wire fire = access && pready_r;
  wire wr_fire = fire && I_PWRITE;
  wire hit_low = I_PADDR == OFS_PC_LOW;
  wire hit_status = I_PADDR == OFS_STATUS;
  wire hit_latch = I_PADDR == OFS_UPPER_LATCH;
  wire hit_index = I_PADDR == OFS_STACK_INDEX;
  wire hit_top_low = I_PADDR == OFS_TOP_LOW;
  wire hit_top_high = I_PADDR == OFS_TOP_HIGH;
  wire hit_ctrl = I_PADDR == OFS_STACK_CTRL;
  wire mapped = hit_low || hit_status || hit_latch || hit_index || hit_top_low
    || hit_top_high || hit_ctrl;
  wire sw_low_we = wr_fire && hit_low;
  wire sw_status_we = wr_fire && hit_status;
  wire sw_latch_we = wr_fire && hit_latch;
  wire sw_index_we = wr_fire && hit_index;
  wire sw_top_low_we = wr_fire && hit_top_low;
  wire sw_top_high_we = wr_fire && hit_top_high;
  wire sw_ctrl_we = wr_fire && hit_ctrl;

  // ==========================================================
  // flow operation decode
  wire is_push = (I_OP == OP_CALL) || (I_OP == OP_CALL_ACC) || (I_OP == OP_IRQ); // see RULE_12
  wire is_pop = (I_OP == OP_RETURN) || (I_OP == OP_RET_LIT) || (I_OP == OP_RET_IRQ); // see RULE_12
  wire overflow = is_push && (count_r == COUNT_FULL);
  wire underflow = is_pop && (count_r == COUNT_RST);
  wire fault = (overflow || underflow) && fault_en_r; // see RULE_16
  wire [3:0] idx_inc = idx_r + 4'h1; // wraps mod 16, see RULE_14
  wire [3:0] idx_dec = idx_r - 4'h1;
  wire [14:0] pc_inc = pc_r + 15'h0001;
  wire [14:0] top_entry = stack_mem[idx_r]; // see RULE_17
  // accumulator treated as unsigned, operand sign extended
  wire [14:0] acc_target = pc_inc + {7'h00, I_ACCUM}; // see RULE_09
  wire [14:0] rel_target = pc_inc + {{6{I_REL_OFFSET[8]}}, I_REL_OFFSET}; // see RULE_10
  // the software low-byte write behaves like the instruction one
  wire [7:0] low_value = (I_OP == OP_WR_LOW) ? I_LOW_WDATA : I_PWDATA[7:0];

  // ==========================================================
  // alu flag computation
  wire [7:0] alu_b_eff = I_ALU_SUB ? ~I_ALU_B : I_ALU_B; // two's complement add
  wire [4:0] nib_sum = {1'b0, I_ALU_A[3:0]} + {1'b0, alu_b_eff[3:0]} + {4'h0, I_ALU_SUB};
  wire [8:0] full_sum = {1'b0, I_ALU_A} + {1'b0, alu_b_eff} + {8'h00, I_ALU_SUB};
  // carry high in subtraction means no borrow
  wire alu_c = full_sum[8]; // see RULE_03
  wire alu_nib = nib_sum[4]; // see RULE_19, RULE_03
  wire [7:0] alu_value = I_ALU_ARITH ? full_sum[7:0] : I_ALU_RESULT;
  wire alu_z = alu_value == 8'h00; // see RULE_22

  // ==========================================================
  // next program counter and stack index
  always_comb
  begin
    pc_nxt = pc_r;
    idx_nxt = idx_r;
    count_nxt = count_r;
    if (fault)
    begin
      // the device is reset, so the counter restarts at zero
      pc_nxt = PC_RST; // see RULE_16, RULE_05
      idx_nxt = IDX_RST;
      count_nxt = COUNT_RST;
    end
    else
    begin
      unique case (I_OP)
        OP_HOLD:
        begin
          pc_nxt = pc_r; // decoder stalled
        end
        OP_NEXT:
        begin
          pc_nxt = pc_inc;
        end
        OP_CALL:
        begin
          pc_nxt = {latch_r[6:3], I_CALL_TARGET}; // see RULE_07
        end
        OP_CALL_ACC:
        begin
          pc_nxt = {latch_r, I_ACCUM}; // see RULE_08
        end
        OP_IRQ:
        begin
          pc_nxt = IRQ_VECTOR;
        end
        OP_JUMP_ACC:
        begin
          pc_nxt = acc_target; // see RULE_09
        end
        OP_JUMP_REL:
        begin
          pc_nxt = rel_target; // see RULE_10
        end
        OP_RETURN, OP_RET_LIT, OP_RET_IRQ:
        begin
          pc_nxt = top_entry; // entry read before the decrement, see RULE_18
        end
        OP_WR_LOW:
        begin
          pc_nxt = {latch_r, low_value}; // see RULE_06
        end
        default:
        begin
          pc_nxt = pc_r; // illegal code, hold
        end
      endcase
      // a software low-byte write only lands while the decoder holds
      if (sw_low_we && (I_OP == OP_HOLD))
      begin
        pc_nxt = {latch_r, low_value}; // see RULE_06, RULE_04
      end
      if (is_push)
      begin
        idx_nxt = idx_inc; // see RULE_18, RULE_14
        count_nxt = overflow ? count_r : count_r + 5'h01; // see RULE_14
      end
      else if (is_pop)
      begin
        idx_nxt = idx_dec; // see RULE_18
        count_nxt = underflow ? count_r : count_r - 5'h01;
      end
      else if (sw_index_we)
      begin
        // moving the index makes everything up to it live
        idx_nxt = I_PWDATA[3:0]; // see RULE_17
        count_nxt = {1'b0, I_PWDATA[3:0]} + 5'h01;
      end
    end
  end

  // ==========================================================
  // upper latch: only software and reset touch it
  assign latch_nxt = fault ? LATCH_RST : (sw_latch_we ? I_PWDATA[6:0] : latch_r); // see RULE_13

  // ==========================================================
  // stack fault flags: set wins over a software clear
  assign full_nxt = overflow
    || (full_r && !(sw_ctrl_we && !I_PWDATA[CTL_FULL])); // see RULE_15
  assign empty_pop_nxt = underflow
    || (empty_pop_r && !(sw_ctrl_we && !I_PWDATA[CTL_EMPTY_POP])); // see RULE_15

  // ==========================================================
  // status next value
  always_comb
  begin
    status_nxt = status_r;
    // software or instruction write reaches the low three bits only
    if (I_STATUS_WE)
    begin
      status_nxt[2:0] = I_STATUS_WDATA[2:0]; // see RULE_02
    end
    else if (sw_status_we)
    begin
      status_nxt[2:0] = I_PWDATA[2:0]; // see RULE_02
    end
    // the result of the operation overrides the written zero bit, and the nibble and carry bits for arithmetic
    if (I_ALU_VALID)
    begin
      status_nxt[ST_Z] = alu_z; // see RULE_01, RULE_22
      if (I_ALU_ARITH)
      begin
        status_nxt[ST_NIB] = alu_nib; // see RULE_01, RULE_19
        status_nxt[ST_C] = alu_c; // see RULE_01, RULE_03
      end
    end
    // watchdog events, time-out takes priority over a clear
    if (I_WDT_TIMEOUT)
    begin
      status_nxt[ST_EXPIRY] = 1'b0; // see RULE_20
    end
    else if (I_WDT_CLEAR || I_SLEEP)
    begin
      status_nxt[ST_EXPIRY] = 1'b1; // see RULE_20
    end
    if (I_SLEEP)
    begin
      status_nxt[ST_PDOWN] = 1'b0; // see RULE_21
    end
    else if (I_WDT_CLEAR)
    begin
      status_nxt[ST_PDOWN] = 1'b1; // see RULE_21
    end
    status_nxt[7:5] = 3'h0; // unimplemented bits read zero
  end

  // ==========================================================
  // flow registers; a fault reset keeps flags and status
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      pc_r <= PC_RST; // see RULE_05
      latch_r <= LATCH_RST;
      idx_r <= IDX_RST;
      count_r <= COUNT_RST;
      fault_rst_r <= 1'b0;
    end
    else
    begin
      pc_r <= pc_nxt;
      latch_r <= latch_nxt;
      idx_r <= idx_nxt;
      count_r <= count_nxt;
      fault_rst_r <= fault; // see RULE_16
    end
  end

  // ==========================================================
  // status and stack control registers
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      status_r <= STATUS_RST; // power-up values, see RULE_20, RULE_21
      fault_en_r <= FAULT_EN_RST;
      full_r <= 1'b0;
      empty_pop_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      fault_en_r <= sw_ctrl_we ? I_PWDATA[CTL_FAULT_EN] : fault_en_r;
      full_r <= full_nxt;
      empty_pop_r <= empty_pop_nxt;
    end
  end

  // ==========================================================
  // stack storage: no reset, contents are undefined until pushed or written by software
  always_ff @(posedge I_CLK)
  begin
    if (is_push && !fault)
    begin
      // written at the incremented index, see RULE_18, RULE_11
      stack_mem[idx_inc] <= pc_r + ((I_OP == OP_IRQ) ? 15'h0000 : 15'h0001); // see RULE_12
    end
    else if (sw_top_low_we && !(is_pop || is_push))
    begin
      // a faulting push must not let a software write slip in
      stack_mem[idx_r] <= {top_entry[14:8], I_PWDATA[7:0]}; // see RULE_17
    end
    else if (sw_top_high_we && !(is_pop || is_push))
    begin
      stack_mem[idx_r] <= {I_PWDATA[6:0], top_entry[7:0]}; // see RULE_17
    end
  end

  // ==========================================================
  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_low)
    begin
      rd_mux[7:0] = pc_r[7:0]; // see RULE_04
    end
    else if (hit_status)
    begin
      rd_mux[7:0] = status_r;
    end
    else if (hit_latch)
    begin
      rd_mux[6:0] = latch_r;
    end
    else if (hit_index)
    begin
      rd_mux[3:0] = idx_r;
    end
    else if (hit_top_low)
    begin
      rd_mux[7:0] = top_entry[7:0];
    end
    else if (hit_top_high)
    begin
      rd_mux[6:0] = top_entry[14:8];
    end
    else if (hit_ctrl)
    begin
      rd_mux[CTL_FAULT_EN] = fault_en_r;
      rd_mux[CTL_FULL] = full_r;
      rd_mux[CTL_EMPTY_POP] = empty_pop_r;
    end
  end

  // ==========================================================
  // apb answer, one wait state, error on unmapped offsets
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= access && !pready_r;
      prdata_r <= (access && !pready_r && !I_PWRITE) ? rd_mux : 32'h0000_0000;
      pslverr_r <= access && !pready_r && !mapped;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign O_PC = pc_r;
  assign O_STATUS = status_r;
  assign O_STACK_FAULT_RESET = fault_rst_r;
  assign O_PREADY = pready_r;
  assign O_PRDATA = prdata_r;
  assign O_PSLVERR = pslverr_r;

endmodule

/* hdl/pcs_pkg.sv */
// constants, offsets and types shared by the program-flow and status unit
package pcs_pkg;

  // ==========================================================
  // widths
  localparam int PC_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int IDX_W = 4;

  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] OFS_PC_LOW = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
  localparam logic [7:0] OFS_STACK_INDEX = 8'h0c;
  localparam logic [7:0] OFS_TOP_LOW = 8'h10;
  localparam logic [7:0] OFS_TOP_HIGH = 8'h14;
  localparam logic [7:0] OFS_STACK_CTRL = 8'h18;

  // ==========================================================
  // status field positions and reset value
  localparam int ST_EXPIRY = 4;
  localparam int ST_PDOWN = 3;
  localparam int ST_Z = 2;
  localparam int ST_NIB = 1;
  localparam int ST_C = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;

  // stack control field positions
  localparam int CTL_FAULT_EN = 0;
  localparam int CTL_FULL = 1;
  localparam int CTL_EMPTY_POP = 2;

  // ==========================================================
  // reset values of the flow state
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [6:0] LATCH_RST = 7'h00;
  localparam logic [3:0] IDX_RST = 4'hf;
  localparam logic [4:0] COUNT_RST = 5'h00;
  localparam logic [4:0] COUNT_FULL = 5'h10;
  localparam logic FAULT_EN_RST = 1'b0;

  // ==========================================================
  // flow operations issued by the instruction decoder
  typedef enum logic [3:0]
  {
    OP_HOLD,
    OP_NEXT,
    OP_CALL,
    OP_CALL_ACC,
    OP_JUMP_ACC,
    OP_JUMP_REL,
    OP_RETURN,
    OP_RET_LIT,
    OP_RET_IRQ,
    OP_IRQ,
    OP_WR_LOW
  } flow_op_e;

endpackage

/* tb/pcs_monitor.sv */
// assertion checker on the ports of the program-flow and status unit
`timescale 1ns/100ps
module pcs_monitor
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // flow requests
  input wire pcs_pkg::flow_op_e I_OP,
  input wire logic [10:0] I_CALL_TARGET,
  input wire logic [8:0] I_REL_OFFSET,
  input wire logic [7:0] I_ACCUM,
  // alu and events
  input wire logic I_ALU_VALID,
  input wire logic I_ALU_ARITH,
  input wire logic I_ALU_SUB,
  input wire logic [7:0] I_ALU_A,
  input wire logic [7:0] I_ALU_B,
  input wire logic [7:0] I_ALU_RESULT,
  input wire logic I_WDT_CLEAR,
  input wire logic I_SLEEP,
  input wire logic I_WDT_TIMEOUT,
  // watched outputs
  input wire logic [14:0] O_PC,
  input wire logic [7:0] O_STATUS,
  input wire logic O_STACK_FAULT_RESET
);
  import pcs_pkg::*;
  // ==========================================================
  // expected carries; subtraction adds the complement plus one
  logic [8:0] sum_w;
  logic [4:0] nib_w;
  assign sum_w = {1'b0, I_ALU_A} + (I_ALU_SUB ? {1'b0, ~I_ALU_B} + 9'h1 : {1'b0, I_ALU_B});
  assign nib_w = {1'b0, I_ALU_A[3:0]}
    + (I_ALU_SUB ? {1'b0, ~I_ALU_B[3:0]} + 5'h1 : {1'b0, I_ALU_B[3:0]});
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // ==========================================================
  // counter loading
  pc_reset_a: assert property ($rose(I_RESETN) |-> O_PC == 15'h0000)
    else $error("counter not cleared by reset");
  call_load_a: assert property (I_OP == OP_CALL |=>
    O_STACK_FAULT_RESET || O_PC[10:0] == $past(I_CALL_TARGET))
    else $error("call target not loaded");
  acc_call_a: assert property (I_OP == OP_CALL_ACC |=>
    O_STACK_FAULT_RESET || O_PC[7:0] == $past(I_ACCUM))
    else $error("accumulator call low byte wrong");
  acc_jump_a: assert property (I_OP == OP_JUMP_ACC |=>
    O_PC == $past(O_PC) + {7'h00, $past(I_ACCUM)} + 15'h0001)
    else $error("accumulator jump target wrong");
  lit_jump_a: assert property (I_OP == OP_JUMP_REL |=>
    O_PC == $past(O_PC) + 15'h0001 + {{6{$past(I_REL_OFFSET[8])}}, $past(I_REL_OFFSET)})
    else $error("literal jump target wrong");
  fault_pulse_a: assert property (O_STACK_FAULT_RESET |->
    O_PC == 15'h0000 ##1 !O_STACK_FAULT_RESET)
    else $error("fault reset pulse wrong");
  // ==========================================================
  // status flags
  ro_flags_a: assert property (!(I_WDT_CLEAR || I_SLEEP || I_WDT_TIMEOUT) |=>
    $stable(O_STATUS[4:3]))
    else $error("expiry or power-down bit moved");
  expiry_clear_a: assert property (I_WDT_TIMEOUT |=> !O_STATUS[4])
    else $error("expiry flag not cleared");
  sleep_clear_a: assert property (I_SLEEP |=> !O_STATUS[3])
    else $error("power-down flag not cleared");
  logic_zero_a: assert property (I_ALU_VALID && !I_ALU_ARITH |=>
    O_STATUS[2] == ($past(I_ALU_RESULT) == 8'h00))
    else $error("zero flag wrong");
  arith_flags_a: assert property (I_ALU_VALID && I_ALU_ARITH |=>
    O_STATUS[2:0] == {$past(sum_w[7:0]) == 8'h00, $past(nib_w[4]), $past(sum_w[8])})
    else $error("arithmetic flags wrong");
endmodule

/* tb/dec_model.sv */
// decoder-side model driving flow, alu and event inputs
`timescale 1ns/100ps
module dec_model
(
  // clock
  input wire logic i_clk,
  // flow request and operand
  output pcs_pkg::flow_op_e o_op,
  output logic [10:0] o_arg,
  // alu {valid, arith, sub, status write} and data
  output logic [3:0] o_ctl,
  output logic [7:0] o_a,
  output logic [7:0] o_b,
  output logic [7:0] o_res,
  output logic [7:0] o_wd,
  // events {clear watchdog, sleep, time-out}
  output logic [2:0] o_ev
);
  import pcs_pkg::*;
  initial
  begin
    o_op = OP_HOLD;
    {o_arg, o_ctl, o_a, o_b, o_res, o_wd, o_ev} = '0;
  end
  // one request lasts one edge, then the decoder idles
  task automatic step();
    @(posedge i_clk);
    o_op <= OP_HOLD;
    o_ctl <= 4'h0;
    o_ev <= 3'h0;
    @(negedge i_clk);
  endtask
  task automatic flow(input flow_op_e op, input logic [10:0] v);
    @(posedge i_clk);
    o_op <= op;
    o_arg <= v;
    step();
  endtask
  task automatic alu(input logic [3:0] c, input logic [7:0] x, y, r, w);
    @(posedge i_clk);
    {o_ctl, o_a, o_b, o_res, o_wd} <= {c, x, y, r, w};
    step();
  endtask
  task automatic ev(input logic [2:0] e);
    @(posedge i_clk);
    o_ev <= e;
    step();
  endtask
endmodule

/* tb/pc_stack_status_unit_test.sv */
// self-checking bench for the program-flow, stack and status unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module pc_stack_status_unit_test;
  import pcs_pkg::*;
  localparam logic [14:0] VEC = 15'h0200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, fault, serr;
  logic [14:0] pc;
  logic [7:0] status, a, b, res, wd;
  logic [10:0] arg;
  logic [3:0] ctl;
  logic [2:0] ev;
  flow_op_e op;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  pc_stack_status_unit #(.IRQ_VECTOR(VEC)) u_pc_stack_status_unit (
    .I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OP(op), .I_CALL_TARGET(arg),
    .I_REL_OFFSET(arg[8:0]), .I_ACCUM(arg[7:0]), .I_LOW_WDATA(arg[7:0]),
    .I_ALU_VALID(ctl[3]), .I_ALU_ARITH(ctl[2]), .I_ALU_SUB(ctl[1]), .I_ALU_A(a),
    .I_ALU_B(b), .I_ALU_RESULT(res), .I_STATUS_WE(ctl[0]), .I_STATUS_WDATA(wd),
    .I_WDT_CLEAR(ev[2]), .I_SLEEP(ev[1]), .I_WDT_TIMEOUT(ev[0]), .O_PC(pc),
    .O_STATUS(status), .O_STACK_FAULT_RESET(fault));
  dec_model u_dec_model (.i_clk(clk), .o_op(op), .o_arg(arg), .o_ctl(ctl),
    .o_a(a), .o_b(b), .o_res(res), .o_wd(wd), .o_ev(ev));
  // ==========================================================
  // apb master: hold the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic fl(input flow_op_e o, input logic [10:0] v);
    u_dec_model.flow(o, v);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================================
  // test sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc("status", OFS_STATUS, 32'h18);
    rdc("index", OFS_STACK_INDEX, 32'hf);
    `CHK("pc", 15'h0, pc)
    apb(1'b1, OFS_UPPER_LATCH, 32'h55);
    apb(1'b1, OFS_PC_LOW, 32'h34);
    `CHK("pc", 15'h5534, pc)
    rdc("pc low", OFS_PC_LOW, 32'h34);
    $display("test counter load done");
    fl(OP_CALL, 11'h123);
    `CHK("pc", 15'h5123, pc)
    rdc("index", OFS_STACK_INDEX, 32'h0);
    rdc("top lo", OFS_TOP_LOW, 32'h35);
    rdc("top hi", OFS_TOP_HIGH, 32'h55);
    fl(OP_CALL_ACC, 11'h09a);
    `CHK("pc", 15'h559a, pc)
    fl(OP_IRQ, 11'h0);
    `CHK("pc", VEC, pc)
    rdc("latch", OFS_UPPER_LATCH, 32'h55);
    fl(OP_RET_IRQ, 11'h0);
    `CHK("pc", 15'h559a, pc)
    fl(OP_RET_LIT, 11'h0);
    `CHK("pc", 15'h5124, pc)
    fl(OP_RETURN, 11'h0);
    `CHK("pc", 15'h5535, pc)
    rdc("index", OFS_STACK_INDEX, 32'hf);
    fl(OP_RETURN, 11'h0);
    `CHK("fault", 1'b0, fault)
    rdc("ctrl", OFS_STACK_CTRL, 32'h4);
    // move the index by software, fill that entry, then pop it
    apb(1'b1, OFS_STACK_INDEX, 32'h3);
    apb(1'b1, OFS_TOP_LOW, 32'h21);
    apb(1'b1, OFS_TOP_HIGH, 32'h12);
    rdc("index", OFS_STACK_INDEX, 32'h3);
    rdc("top lo", OFS_TOP_LOW, 32'h21);
    rdc("top hi", OFS_TOP_HIGH, 32'h12);
    fl(OP_RETURN, 11'h0);
    `CHK("pc", 15'h1221, pc)
    rdc("index", OFS_STACK_INDEX, 32'h2);
    $display("test push pop done");
    apb(1'b1, OFS_STACK_CTRL, 32'h0);
    apb(1'b1, OFS_PC_LOW, 32'h10);
    fl(OP_JUMP_ACC, 11'h0ff);
    `CHK("pc", 15'h5610, pc)
    fl(OP_JUMP_REL, 11'h1f0);
    `CHK("pc", 15'h5601, pc)
    fl(OP_WR_LOW, 11'h077);
    `CHK("pc", 15'h5577, pc)
    fl(OP_NEXT, 11'h0);
    `CHK("pc", 15'h5578, pc)
    $display("test branches done");
    // second reset, then seventeen calls wrap the stack
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 1; i < 18; i++)
      fl(OP_CALL, 11'(i));
    rdc("index", OFS_STACK_INDEX, 32'h0);
    rdc("top lo", OFS_TOP_LOW, 32'h11);
    rdc("ctrl", OFS_STACK_CTRL, 32'h2);
    apb(1'b1, OFS_STACK_CTRL, 32'h1);
    fl(OP_CALL, 11'h3ff);
    `CHK("fault", 1'b1, fault)
    `CHK("pc", 15'h0, pc)
    rdc("ctrl", OFS_STACK_CTRL, 32'h3);
    fl(OP_RETURN, 11'h0);
    `CHK("fault", 1'b1, fault)
    rdc("ctrl", OFS_STACK_CTRL, 32'h7);
    $display("test stack faults done");
    `CHK("status", 8'h18, status)
    u_dec_model.alu(4'hd, 8'h08, 8'h08, 8'h10, 8'h07);
    `CHK("status", 8'h1a, status)
    u_dec_model.alu(4'hc, 8'hf0, 8'h10, 8'h00, 8'h00);
    `CHK("status", 8'h1d, status)
    u_dec_model.alu(4'he, 8'h10, 8'h01, 8'h0f, 8'h00);
    `CHK("status", 8'h19, status)
    u_dec_model.alu(4'h8, 8'h00, 8'h00, 8'h00, 8'h00);
    `CHK("status", 8'h1d, status)
    u_dec_model.alu(4'h1, 8'h00, 8'h00, 8'h00, 8'h00);
    `CHK("status", 8'h18, status)
    apb(1'b1, OFS_STATUS, 32'hff);
    `CHK("status", 8'h1f, status)
    u_dec_model.ev(3'h2);
    `CHK("status", 8'h17, status)
    u_dec_model.ev(3'h1);
    `CHK("status", 8'h07, status)
    u_dec_model.ev(3'h4);
    `CHK("status", 8'h1f, status)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("slverr", 1'b1, serr)
    `CHK("rdata", 32'h0, rd)
    $display("test status done");
    print_verdict();
  end
endmodule
bind pc_stack_status_unit pcs_monitor u_pcs_monitor (.*);
